// ---- scp_pkg.sv ----
// Constants and types shared by the serial configuration port
// Operation
// RQ1 - Chip select is active low; only a low level selects the port.
// RQ2 - Command capture starts with the first serial bit after select.
// RQ3 - First command bit is direction: one reads, zero writes.
// RQ4 - Next fifteen bits form the start address latched for the transaction.
// RQ5 - Each further data word advances the address by one.
// RQ6 - Every configuration register and the pattern memory are readable and writable.
// RQ7 - Writes keep the data line an input; reads drive data out.
// RQ8 - Chip select high ends the transaction, stops driving, resets capture.
// RQ9 - Addresses 0x6000 to 0x6FFF go to the pattern memory.
// RQ10 - Dual-input write mode turns the spare pin into a second data input.
// RQ11 - MSB first; sample on rising serial clock, launch on falling edge.
package scp_pkg;

	localparam int WORD_W = 16;
	localparam int ADDR_W = 15;
	localparam logic [4:0] CMD_LAST_BIT = 5'h0F;
	localparam logic [4:0] WORD_BITS = 5'h10;
	localparam logic [14:0] SRAM_BASE = 15'h6000;
	localparam logic [14:0] SRAM_LAST = 15'h6FFF;
	localparam int SRAM_DEPTH = 4096;
	localparam int SRAM_W = 14;
	localparam int CFG_REGS = 64;
	localparam logic [15:0] CFG_RESET = 16'h0000;

	// Transaction progress
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_CMD = 2'b01,
		ST_DATA = 2'b10
	} scp_state_t;

	// Where an address lands
	typedef enum logic [1:0]
	{
		TG_NONE = 2'b00,
		TG_CFG = 2'b01,
		TG_SRAM = 2'b10
	} scp_target_t;

endpackage : scp_pkg

// ---- scp_link_if.sv ----
// Synchronised serial link events passed from the pin stage to the port
`timescale 1ns/100ps
interface scp_link_if;
	logic csActive;
	logic sclkRise;
	logic sclkFall;
	logic dataBit0;
	logic dataBit1;
	logic fourWire;
	logic dualMode;

	modport producer (output csActive, sclkRise, sclkFall, dataBit0,
		dataBit1, fourWire, dualMode);
	modport consumer (input csActive, sclkRise, sclkFall, dataBit0,
		dataBit1, fourWire, dualMode);
endinterface : scp_link_if

// ---- scp_pin_sync.sv ----
// Two-stage pin synchronisers and serial clock edge detection
`timescale 1ns/100ps
module scp_pin_sync
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic csN,
	input wire logic sclk,
	input wire logic sdioIn,
	input wire logic sdoIn,
	input wire logic fourWire,
	input wire logic dualWrite,
	scp_link_if.producer lnk
);

	logic [5:0] stage1;
	logic [5:0] stage2;
	logic sclkPrev;

	// Both stages; only stage2 reads stage1
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			stage1 <= 6'h01;
			stage2 <= 6'h01;
		end
		else
		begin
			stage1 <= {dualWrite, fourWire, sdoIn, sdioIn, sclk, csN};
			stage2 <= stage1;
		end
	end

	// Edge finder and link outputs
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			sclkPrev <= 1'b0;
			lnk.csActive <= 1'b0;
			lnk.sclkRise <= 1'b0;
			lnk.sclkFall <= 1'b0;
			lnk.dataBit0 <= 1'b0;
			lnk.dataBit1 <= 1'b0;
			lnk.fourWire <= 1'b0;
			lnk.dualMode <= 1'b0;
		end
		else
		begin
			sclkPrev <= stage2[1];
			// RQ1 low selects
			lnk.csActive <= ~stage2[0];
			lnk.sclkRise <= stage2[1] & ~sclkPrev;
			lnk.sclkFall <= ~stage2[1] & sclkPrev;
			lnk.dataBit0 <= stage2[2];
			lnk.dataBit1 <= stage2[3];
			lnk.fourWire <= stage2[4];
			lnk.dualMode <= stage2[5];
		end
	end

endmodule : scp_pin_sync

// ---- scp_serial_config_port.sv ----
// Serial slave port reaching configuration registers and pattern memory
`timescale 1ns/100ps
module scp_serial_config_port
#(
	parameter int CFG_REGS = scp_pkg::CFG_REGS,
	parameter int SRAM_DEPTH = scp_pkg::SRAM_DEPTH
)
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic csN,
	input wire logic sclk,
	input wire logic sdioIn,
	output logic sdioOut,
	output logic sdioOe,
	input wire logic sdoIn,
	output logic sdoOut,
	output logic sdoOe,
	input wire logic fourWire,
	input wire logic dualWrite,
	output logic [CFG_REGS*scp_pkg::WORD_W-1:0] cfgRegs,
	input wire logic [11:0] patAddr,
	output logic [scp_pkg::SRAM_W-1:0] patData
);

	scp_link_if lnk();

	scp_pin_sync scp_pin_sync_inst
	(
		.ref_clk(ref_clk),
		.rstn(rstn),
		.csN(csN),
		.sclk(sclk),
		.sdioIn(sdioIn),
		.sdoIn(sdoIn),
		.fourWire(fourWire),
		.dualWrite(dualWrite),
		.lnk(lnk)
	);

	scp_pkg::scp_state_t state;
	logic [4:0] bitCnt;
	logic [15:0] rxShift;
	logic [15:0] txShift;
	logic [14:0] addr;
	logic isRead;
	logic [15:0] cfgMem [CFG_REGS];
	logic [scp_pkg::SRAM_W-1:0] patMem [SRAM_DEPTH];

	logic cmdDone;
	logic dualActive;
	logic [4:0] bitStep;
	logic wordDone;
	logic writeStrobe;
	logic cfgWe;
	logic sramWe;
	logic [15:0] next_rx;
	logic [14:0] readAddr;
	logic [15:0] readData;

	////////////////////////////////////////////////////////////////////////
	// Address decode, used for reads and writes
	function automatic scp_pkg::scp_target_t targetOf(input logic [14:0] a);
		if (a >= scp_pkg::SRAM_BASE && a <= scp_pkg::SRAM_LAST)
			return scp_pkg::TG_SRAM;
		else if (32'(a) < CFG_REGS)
			return scp_pkg::TG_CFG;
		else
			return scp_pkg::TG_NONE;
	endfunction : targetOf

	function automatic logic [11:0] sramIndex(input logic [14:0] a);
		logic [14:0] off;
		off = a - scp_pkg::SRAM_BASE;
		return off[11:0];
	endfunction : sramIndex

	// Step and word-completion terms
	always_comb
	begin
		cmdDone = state == scp_pkg::ST_CMD && lnk.sclkRise
			&& bitCnt == scp_pkg::CMD_LAST_BIT;
		// RQ10 two bits per edge, data words only: the command and a stale
		// direction flag from the last transaction must not double the step
		dualActive = lnk.dualMode && !isRead && state == scp_pkg::ST_DATA;
		bitStep = dualActive ? 5'h02 : 5'h01;
		next_rx = dualActive ? {rxShift[13:0], lnk.dataBit0, lnk.dataBit1}
			: {rxShift[14:0], lnk.dataBit0};
		wordDone = state == scp_pkg::ST_DATA && lnk.sclkRise
			&& (bitCnt + bitStep) == scp_pkg::WORD_BITS;
		writeStrobe = wordDone && !isRead;
		// RQ9 memory window routing
		cfgWe = writeStrobe && targetOf(addr) == scp_pkg::TG_CFG;
		sramWe = writeStrobe && targetOf(addr) == scp_pkg::TG_SRAM;
		readAddr = cmdDone ? {rxShift[13:0], lnk.dataBit0} : addr + 15'h0001;
	end

	// Read mux over both spaces
	always_comb
	begin
		readData = 16'h0000;
		case (targetOf(readAddr))
			scp_pkg::TG_CFG: readData = cfgMem[readAddr[5:0]];
			scp_pkg::TG_SRAM: readData = {2'h0, patMem[sramIndex(readAddr)]};
			default: readData = 16'h0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Transaction state and bit counter
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			state <= scp_pkg::ST_IDLE;
			bitCnt <= 5'h00;
		end
		// RQ8 deselect resets capture
		else if (!lnk.csActive)
		begin
			state <= scp_pkg::ST_IDLE;
			bitCnt <= 5'h00;
		end
		else
		begin
			case (state)
				// RQ2 capture from next bit
				scp_pkg::ST_IDLE:
				begin
					state <= scp_pkg::ST_CMD;
					bitCnt <= 5'h00;
				end
				scp_pkg::ST_CMD:
				begin
					if (cmdDone)
					begin
						state <= scp_pkg::ST_DATA;
						bitCnt <= 5'h00;
					end
					else if (lnk.sclkRise)
						bitCnt <= bitCnt + 5'h01;
				end
				scp_pkg::ST_DATA:
				begin
					if (wordDone)
						bitCnt <= 5'h00;
					else if (lnk.sclkRise)
						bitCnt <= bitCnt + bitStep;
				end
				default:
				begin
					state <= scp_pkg::ST_IDLE;
					bitCnt <= 5'h00;
				end
			endcase
		end
	end

	// RQ11 MSB-first sampling on rise
	always_ff @(posedge ref_clk)
	begin
		if (!rstn || !lnk.csActive)
			rxShift <= 16'h0000;
		else if (lnk.sclkRise && state != scp_pkg::ST_IDLE)
			rxShift <= next_rx;
	end

	// Direction and address latch, auto increment
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			isRead <= 1'b0;
			addr <= 15'h0000;
		end
		// RQ3 direction flag
		else if (cmdDone)
		begin
			isRead <= rxShift[14];
			// RQ4 start address
			addr <= {rxShift[13:0], lnk.dataBit0};
		end
		// RQ5 next word address
		else if (wordDone)
			addr <= addr + 15'h0001;
	end

	////////////////////////////////////////////////////////////////////////
	// RQ6 configuration register writes
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < CFG_REGS; i++)
				cfgMem[i] <= scp_pkg::CFG_RESET;
		end
		else if (cfgWe)
			cfgMem[addr[5:0]] <= next_rx;
	end

	// RQ6 pattern memory writes
	always_ff @(posedge ref_clk)
	begin
		if (sramWe)
			patMem[sramIndex(addr)] <= next_rx[scp_pkg::SRAM_W-1:0];
	end

	// Pattern read port for the waveform side
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			patData <= '0;
		else
			patData <= patMem[patAddr];
	end

	// Register contents presented to the device
	generate
		for (genvar g = 0; g < CFG_REGS; g++)
		begin : gCfgOut
			assign cfgRegs[g*scp_pkg::WORD_W +: scp_pkg::WORD_W] = cfgMem[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Read word shifter
	always_ff @(posedge ref_clk)
	begin
		if (!rstn || !lnk.csActive)
			txShift <= 16'h0000;
		else if ((cmdDone && rxShift[14]) || (wordDone && isRead))
			txShift <= readData;
		else if (state == scp_pkg::ST_DATA && isRead && lnk.sclkFall)
			txShift <= {txShift[14:0], 1'b0};
	end

	// Output pins, launched on falling serial clock
	always_ff @(posedge ref_clk)
	begin
		// RQ8 stop driving on deselect
		if (!rstn || !lnk.csActive)
		begin
			sdioOut <= 1'b0;
			sdioOe <= 1'b0;
			sdoOut <= 1'b0;
			sdoOe <= 1'b0;
		end
		// RQ7 drive only for reads
		else if (state == scp_pkg::ST_DATA && isRead && lnk.sclkFall)
		begin
			if (lnk.fourWire && !lnk.dualMode)
			begin
				sdoOut <= txShift[15];
				sdoOe <= 1'b1;
			end
			else
			begin
				sdioOut <= txShift[15];
				sdioOe <= 1'b1;
			end
		end
		else if (state != scp_pkg::ST_DATA || !isRead)
		begin
			sdioOe <= 1'b0;
			sdoOe <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence s_cmdEnd;
		cmdDone;
	endsequence

	sequence s_readFall;
		state == scp_pkg::ST_DATA && isRead && lnk.sclkFall
			&& lnk.csActive;
	endsequence

	property p_deselect;
		!lnk.csActive |=> state == scp_pkg::ST_IDLE && !sdioOe && !sdoOe;
	endproperty
	a_deselect: assert property (p_deselect) // RQ1
		else $error("port active while deselected");

	property p_selectStart;
		$rose(lnk.csActive) |=> state == scp_pkg::ST_CMD && bitCnt == 5'h00;
	endproperty
	a_selectStart: assert property (p_selectStart) // RQ2
		else $error("command capture did not start");

	property p_direction;
		s_cmdEnd |=> isRead == $past(rxShift[14]) && state == scp_pkg::ST_DATA;
	endproperty
	a_direction: assert property (p_direction) // RQ3
		else $error("direction flag not latched");

	property p_startAddr;
		s_cmdEnd |=> addr == {$past(rxShift[13:0]), $past(lnk.dataBit0)};
	endproperty
	a_startAddr: assert property (p_startAddr) // RQ4
		else $error("start address wrong");

	property p_increment;
		wordDone && lnk.csActive |=> addr == $past(addr) + 15'h0001;
	endproperty
	a_increment: assert property (p_increment) // RQ5
		else $error("address did not advance");

	property p_cfgWrite;
		cfgWe |=> cfgMem[$past(addr[5:0])] == $past(next_rx);
	endproperty
	a_cfgWrite: assert property (p_cfgWrite) // RQ6
		else $error("register write lost");

	property p_writeQuiet;
		state == scp_pkg::ST_DATA && !isRead |=> ##1 !sdioOe && !sdoOe;
	endproperty
	a_writeQuiet: assert property (p_writeQuiet) // RQ7
		else $error("pin driven during write");

	property p_sramRoute;
		sramWe |-> !cfgWe && addr >= scp_pkg::SRAM_BASE
			&& addr <= scp_pkg::SRAM_LAST;
	endproperty
	a_sramRoute: assert property (p_sramRoute) // RQ9
		else $error("memory window misrouted");

	property p_dualStep;
		dualActive && lnk.sclkRise && state == scp_pkg::ST_DATA && !wordDone
			&& lnk.csActive |=> bitCnt == $past(bitCnt) + 5'h02;
	endproperty
	a_dualStep: assert property (p_dualStep) // RQ10
		else $error("dual mode did not take two bits");

	property p_launch;
		s_readFall |=> (sdioOe && sdioOut == $past(txShift[15]))
			|| (sdoOe && sdoOut == $past(txShift[15]));
	endproperty
	a_launch: assert property (p_launch) // RQ11
		else $error("read bit not launched on falling edge");

endmodule : scp_serial_config_port

// ---- scp_spi_master.sv ----
// SPI master model that drives the serial configuration port pins
`timescale 1ns/100ps
module scp_spi_master
(
	input wire logic ref_clk,
	input wire logic sdioLine,
	input wire logic sdoLine,
	output logic csN,
	output logic sclk,
	output logic sdioDrv,
	output logic sdoDrv
);
	initial
	begin
		csN = 1'b1;
		sclk = 1'b0;
		sdioDrv = 1'b0;
		sdoDrv = 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// Half a serial clock period, so the link runs at 160 ns
	task automatic half_wait();
		repeat (20) @(posedge ref_clk);
	endtask : half_wait

	task automatic shift(input logic [15:0] w, input logic dual,
		input logic useSdo, output logic [15:0] r);
		for (int i = (dual ? 7 : 15); i >= 0; i--)
		begin
			sclk <= 1'b0;
			sdioDrv <= dual ? w[2*i+1] : w[i];
			sdoDrv <= dual ? w[2*i] : ~sdoDrv;
			half_wait();
			sclk <= 1'b1;
			r[i] = useSdo ? sdoLine : sdioLine;
			half_wait();
		end
	endtask : shift

	task automatic open_cmd(input logic rd, input logic [14:0] a);
		logic [15:0] unused;
		@(posedge ref_clk);
		csN <= 1'b0;
		half_wait();
		shift({rd, a}, 1'b0, 1'b0, unused);
	endtask : open_cmd

	task automatic close_cmd();
		half_wait();
		sclk <= 1'b0;
		sdioDrv <= ~sdioDrv;
		half_wait();
		csN <= 1'b1;
		half_wait();
	endtask : close_cmd
endmodule : scp_spi_master

// ---- scp_serial_config_port_test.sv ----
// Self-checking bench for the serial configuration port
`timescale 1ns/100ps
module scp_serial_config_port_test;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic fourWire = 1'b0;
	logic dualWrite = 1'b0;
	logic [11:0] patAddr = 12'h000;
	logic csN, sclk, sdioDrv, sdoDrv, sdioOut, sdioOe, sdoOut, sdoOe;
	logic sdioLine, sdoLine;
	logic [scp_pkg::CFG_REGS*scp_pkg::WORD_W-1:0] cfgRegs;
	logic [scp_pkg::SRAM_W-1:0] patData;
	logic [15:0] r;
	int fails = 0;
	int checks_done = 0;

	// Reference clock, 4 ns period
	always #2 ref_clk = ~ref_clk;

	// Wire level from the port's enables; the master drives the line otherwise
	assign sdioLine = sdioOe ? sdioOut : sdioDrv;
	assign sdoLine = sdoOe ? sdoOut : sdoDrv;

	scp_serial_config_port scp_serial_config_port_inst
	(
		.ref_clk, .rstn, .csN, .sclk, .sdioIn(sdioLine), .sdioOut,
		.sdioOe, .sdoIn(sdoLine), .sdoOut, .sdoOe, .fourWire,
		.dualWrite, .cfgRegs, .patAddr, .patData
	);

	scp_spi_master scp_spi_master_inst
	(
		.ref_clk, .sdioLine, .sdoLine, .csN, .sclk, .sdioDrv, .sdoDrv
	);

	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want)
		begin
			fails++;
			$display("BAD %0t got %h want %h", $time, seen, want);
		end
	endtask : check

	function automatic logic [15:0] cfg(input int g);
		return cfgRegs[16*g +: 16];
	endfunction : cfg

	task automatic cycles(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cycles

	task automatic op(input logic rd, input logic [14:0] a);
		scp_spi_master_inst.open_cmd(rd, a);
	endtask : op

	task automatic sh(input logic [15:0] w, input logic d, input logic s);
		scp_spi_master_inst.shift(w, d, s, r);
	endtask : sh

	task automatic cl();
		scp_spi_master_inst.close_cmd();
	endtask : cl

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check(cfg(0), 16'h0000);
		check(cfg(63), 16'h0000);
		check({14'h0000, sdioOe, sdoOe}, 16'h0000);
		$display("test reset done");
	endtask : t_reset

	// Burst over the last two registers, then past the map
	task automatic t_cfg();
		op(1'b0, 15'h003E);
		sh(16'hA5C3, 1'b0, 1'b0);
		sh(16'h5A3C, 1'b0, 1'b0);
		sh(16'hFFFF, 1'b0, 1'b0);
		check({15'h0000, sdioOe}, 16'h0000);
		cl();
		check(cfg(62), 16'hA5C3);
		check(cfg(63), 16'h5A3C);
		$display("test cfg write done");
	endtask : t_cfg

	task automatic t_read();
		op(1'b1, 15'h003E);
		// Master leaves ones on the line, so an undriven bit cannot pass
		sh(16'hFFFF, 1'b0, 1'b0);
		check(r, 16'hA5C3);
		check({15'h0000, sdioOe}, 16'h0001);
		sh(16'hFFFF, 1'b0, 1'b0);
		check(r, 16'h5A3C);
		sh(16'hFFFF, 1'b0, 1'b0);
		check(r, 16'h0000);
		cl();
		check({15'h0000, sdioOe}, 16'h0000);
		$display("test cfg read done");
	endtask : t_read

	task automatic t_four();
		fourWire <= 1'b1;
		op(1'b1, 15'h003F);
		sh(16'h0000, 1'b0, 1'b1);
		check(r, 16'h5A3C);
		check({15'h0000, sdoOe}, 16'h0001);
		check({15'h0000, sdioOe}, 16'h0000);
		cl();
		fourWire <= 1'b0;
		$display("test four wire done");
	endtask : t_four

	// Top end of the pattern memory window
	task automatic t_sram();
		op(1'b0, 15'h6FFE);
		sh(16'hFFFF, 1'b0, 1'b0);
		sh(16'h1234, 1'b0, 1'b0);
		cl();
		patAddr <= 12'hFFE;
		cycles(3);
		check({2'b00, patData}, 16'h3FFF);
		patAddr <= 12'hFFF;
		cycles(3);
		check({2'b00, patData}, 16'h1234);
		op(1'b1, 15'h6FFE);
		sh(16'h0000, 1'b0, 1'b0);
		check(r, 16'h3FFF);
		cl();
		$display("test pattern memory done");
	endtask : t_sram

	// Dual write, then a read with both straps set answers on sdio
	task automatic t_dual();
		dualWrite <= 1'b1;
		op(1'b0, 15'h6000);
		sh(16'h2BCD, 1'b1, 1'b0);
		cl();
		fourWire <= 1'b1;
		op(1'b1, 15'h6000);
		sh(16'hFFFF, 1'b0, 1'b0);
		check(r, 16'h2BCD);
		check({15'h0000, sdioOe}, 16'h0001);
		cl();
		fourWire <= 1'b0;
		dualWrite <= 1'b0;
		patAddr <= 12'h000;
		cycles(3);
		check({2'b00, patData}, 16'h2BCD);
		$display("test dual write done");
	endtask : t_dual

	// Half a word then deselect, then a clean write
	task automatic t_abort();
		op(1'b0, 15'h0005);
		sh(16'hFFFF, 1'b1, 1'b0);
		cl();
		check(cfg(5), 16'h0000);
		op(1'b0, 15'h0005);
		sh(16'h0101, 1'b0, 1'b0);
		cl();
		check(cfg(5), 16'h0101);
		$display("test abort done");
	endtask : t_abort

	// Reset in mid-run restores defaults, then a write works again
	task automatic t_rerst();
		rstn <= 1'b0;
		cycles(2);
		rstn <= 1'b1;
		cycles(10);
		check(cfg(5), 16'h0000);
		check(cfg(62), 16'h0000);
		op(1'b0, 15'h0001);
		sh(16'hC3A5, 1'b0, 1'b0);
		cl();
		check(cfg(1), 16'hC3A5);
		$display("test mid-run reset done");
	endtask : t_rerst

	////////////////////////////////////////////////////////////////////
	// Main sequence after a two cycle reset
	initial
	begin
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		cycles(10);
		t_reset();
		t_cfg();
		t_read();
		t_four();
		t_sram();
		t_dual();
		t_abort();
		t_rerst();
		final_report();
	end

	// Watchdog, about two and a half times the expected run
	initial
	begin
		repeat (40000) @(posedge ref_clk);
		fails++;
		final_report();
	end
endmodule : scp_serial_config_port_test
